// ---- dv/host_pin_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module host_pin_model (
    input  wire logic want,       // Level the host intends.
    output logic      chip_enable = 1'b0 // Enable pin.
);
    // The host is not on our clock, so the pin moves in mid-cycle.
    always @(want) chip_enable <= #37 want;
endmodule
`default_nettype wire

// ---- dv/reset_control_sequencer_checker.sv ----
`timescale 1ns/1ns
`default_nettype none
module reset_control_sequencer_checker (
    input wire logic       clock,              // Clock.
    input wire logic       srst,               // Reset.
    input wire logic       supply_rise,        // Event.
    input wire logic       stop_exec,          // Event.
    input wire logic       chip_enable,        // Pin.
    input wire logic       halt_force_reset,   // Pulse.
    input wire logic       partial_ctrl_reset, // Pulse.
    input wire logic       full_reset,         // Pulse.
    input wire logic       halt_active,        // Level.
    input wire logic       carry_ff,           // Flag.
    input wire logic       carry_pulse,        // Wave.
    input wire logic       osc_run,            // Level.
    input wire logic [3:0] timer_mode,         // Mode.
    input wire logic       reset_pending       // Level.
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    property p_pon; supply_rise |=> halt_force_reset && full_reset && halt_active; endproperty
    a_pon: assert property (p_pon) else $error("power-on pulses missing");
    property p_stop; stop_exec && !supply_rise |=> full_reset && !osc_run; endproperty
    a_stop: assert property (p_stop) else $error("stop reset missing");
    property p_pair; halt_force_reset |-> partial_ctrl_reset && full_reset; endproperty
    a_pair: assert property (p_pair) else $error("halt reset alone");
    property p_part; partial_ctrl_reset |-> halt_force_reset && timer_mode == 4'h0; endproperty
    a_part: assert property (p_part) else $error("partial reset wrong");
    property p_ce; full_reset && !partial_ctrl_reset |-> $rose(carry_pulse) && $past(reset_pending);
    endproperty
    a_ce: assert property (p_ce) else $error("enable reset off carry edge");
    property p_sync; $rose(chip_enable) |-> ##[2:4] reset_pending; endproperty
    a_sync: assert property (p_sync) else $error("enable rise not seen");
    property p_pend; $fell(reset_pending) |-> full_reset; endproperty
    a_pend: assert property (p_pend) else $error("pending lost");
    property p_halt; $fell(halt_active) |-> carry_ff && $rose(carry_pulse); endproperty
    a_halt: assert property (p_halt) else $error("halt ended without carry");
endmodule
bind reset_control_sequencer reset_control_sequencer_checker chk (.clock(clock), .srst(srst),
    .supply_rise(supply_rise), .stop_exec(stop_exec), .chip_enable(chip_enable),
    .halt_force_reset(halt_force_reset), .partial_ctrl_reset(partial_ctrl_reset),
    .full_reset(full_reset), .halt_active(halt_active), .carry_ff(carry_ff),
    .carry_pulse(carry_pulse), .osc_run(osc_run), .timer_mode(timer_mode),
    .reset_pending(reset_pending));
`default_nettype wire

// ---- dv/tb_reset_control_sequencer.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_reset_control_sequencer;
    logic            clock = 1'b0;
    logic            srst = 1'b1;
    logic            clock_enable = 1'b1;
    logic            supply_rise = 1'b0;
    logic            stop_exec = 1'b0;
    logic            mode_write = 1'b0;
    logic            carry_ff_clear = 1'b0;
    logic            want = 1'b0;
    logic            cp;
    logic [3:0]      mode_data = 4'h0;
    logic [3:0]      md;
    wire logic       chip_enable, halt_force_reset, partial_ctrl_reset, full_reset, halt_active;
    wire logic       carry_ff, carry_pulse, osc_run, reset_pending;
    wire logic [3:0] timer_mode;
    int              bad_count = 0, check_count = 0, seed = 32'h7f8b, n;
    always #50 clock = ~clock;
    host_pin_model host (.want(want), .chip_enable(chip_enable));
    reset_control_sequencer #(.half_1ms_cycles(3), .half_5ms_cycles(5), .half_100ms_cycles(20),
        .half_250ms_cycles(40)) uut (.clock(clock), .srst(srst), .clock_enable(clock_enable),
        .supply_rise(supply_rise), .chip_enable(chip_enable), .stop_exec(stop_exec),
        .mode_write(mode_write), .mode_data(mode_data), .carry_ff_clear(carry_ff_clear),
        .halt_force_reset(halt_force_reset), .partial_ctrl_reset(partial_ctrl_reset),
        .full_reset(full_reset), .halt_active(halt_active), .carry_ff(carry_ff),
        .carry_pulse(carry_pulse), .osc_run(osc_run), .timer_mode(timer_mode),
        .reset_pending(reset_pending));
    function automatic int half_of(input logic [1:0] sel);
        return sel == 2'h0 ? 20 : sel == 2'h1 ? 40 : sel == 2'h2 ? 5 : 3;
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        $display("checks=%0d bad=%0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic pulse(input int which, input logic [3:0] d);
        @(posedge clock);
        mode_data <= d;
        {supply_rise, stop_exec, carry_ff_clear, mode_write} <= 4'h8 >> which;
        @(posedge clock);
        {supply_rise, stop_exec, carry_ff_clear, mode_write} <= 4'h0;
        #1;
    endtask
    // Waits for the forced halt to end, or for a full reset pulse, counting edges.
    task automatic wait_on(input logic halt_wait, output int cycles);
        cycles = 0;
        do begin
            @(posedge clock);
            #1 cycles++;
        end while ((halt_wait ? halt_active : ~full_reset) !== 1'b0 && cycles < 300);
        if (cycles >= 300) begin
            bad_count++;
            conclude();
        end
    endtask
    initial begin
        repeat (5) @(posedge clock);
        srst <= 1'b0;
        pulse(0, 4'h0);
        check({halt_force_reset, partial_ctrl_reset, full_reset, timer_mode}, 7'h70);
        wait_on(1'b1, n);
        check({carry_ff, n <= 22}, 2'h3);
        pulse(2, 4'h0);
        check(carry_ff, 1'b0);
        for (int m = 0; m < 4; m++) begin
            md = {2'($random(seed)), 2'(m)};
            pulse(3, md);
            repeat ({$random(seed)} % 60 + 1) @(posedge clock);
            want <= 1'b1;
            wait_on(1'b0, n);
            check(n > 2 && n <= 2 * half_of(md[1:0]) + 4, 1'b1);
            check({halt_force_reset, partial_ctrl_reset, timer_mode}, {2'h0, md});
            check(reset_pending, 1'b0);
            @(posedge clock) want <= 1'b0;
        end
        pulse(1, 4'h0);
        check({osc_run, partial_ctrl_reset, timer_mode}, 6'h10);
        repeat (10) @(posedge clock);
        want <= 1'b1;
        wait_on(1'b0, n);
        check(n >= 22 && n <= 24, 1'b1);
        check({halt_active, carry_ff}, 2'h1);
        @(posedge clock) clock_enable <= 1'b0;
        #1 cp = carry_pulse;
        repeat (50) @(posedge clock);
        #1 check(carry_pulse, cp);
        conclude();
    end
endmodule
`default_nettype wire

// ---- verilog/reset_control_sequencer.sv ----
// Notes on behaviour
// - Three reset sources: supply rise, enable rise and clock stop.
// - Detect low-to-high transition on enable pin.
// - Power-on clears everything, restarts at zero.
// - Enable reset clears core, some control registers.
// - Clock-stop instruction also triggers reset control.
// - Halt-forcing reset on power-on and stop only.
// - Forced halt ends when carry flag sets.
// - Partial reset on power-on and stop only.
// - Full reset on all three events.
// - Enable reset waits for next carry pulse edge.
// - Enable reset keeps timer mode selection.
// - Fire on currently selected carry period edge.
// - Delay below one period; program keeps running. Code: up to one period plus the synchroniser cycles.
// - Stop clears timer mode, selecting 100 ms.
// - After stop, reset lands 50 ms post enable.
`timescale 1ns/1ns
`default_nettype none

module reset_control_sequencer #(
    parameter int half_1ms_cycles   = reset_seq_pkg::half_1ms_cycles,
    parameter int half_5ms_cycles   = reset_seq_pkg::half_5ms_cycles,
    parameter int half_100ms_cycles = reset_seq_pkg::half_100ms_cycles,
    parameter int half_250ms_cycles = reset_seq_pkg::half_250ms_cycles
) (
    input  wire logic       clock,              // System clock, 10 MHz.
    input  wire logic       srst,               // Synchronous reset, active high.
    input  wire logic       clock_enable,       // Freezes all state while low.
    input  wire logic       supply_rise,        // Pulse from the supply voltage detector.
    input  wire logic       chip_enable,        // Enable pin level.
    input  wire logic       stop_exec,          // Pulse when clock stop executes.
    input  wire logic       mode_write,         // Pulse writing the timer mode select.
    input  wire logic [3:0] mode_data,          // Value for the timer mode select.
    input  wire logic       carry_ff_clear,     // Pulse clearing the carry flag.
    output logic            halt_force_reset,   // One-cycle halt-forcing reset.
    output logic            partial_ctrl_reset, // One-cycle partial control reset.
    output logic            full_reset,         // One-cycle full reset, PC to zero.
    output logic            halt_active,        // Forced halt in effect.
    output logic            carry_ff,           // Timer carry flag.
    output logic            carry_pulse,        // Carry setting pulse waveform.
    output logic            osc_run,            // Oscillator running.
    output logic [3:0]      timer_mode,         // Timer mode select register.
    output logic            reset_pending       // Enable edge awaiting its reset.
);

    localparam int cw = reset_seq_pkg::count_width;

    reset_seq_pkg::seq_state_type state;
    reset_seq_pkg::seq_state_type next_state;

    // Half period of the carry setting pulse for a given mode.
    function automatic logic [cw-1:0] half_period(input logic [3:0] mode);
        logic [cw-1:0] result;
        result = cw'(half_100ms_cycles);
        unique case (mode[1:0])
            reset_seq_pkg::sel_100ms: result = cw'(half_100ms_cycles);
            reset_seq_pkg::sel_250ms: result = cw'(half_250ms_cycles);
            reset_seq_pkg::sel_5ms:   result = cw'(half_5ms_cycles);
            reset_seq_pkg::sel_1ms:   result = cw'(half_1ms_cycles);
        endcase
        return result;
    endfunction

    // True while the carry oscillator runs; the wave only advances then.
    function automatic logic osc_live(input reset_seq_pkg::osc_state_type osc);
        return osc == reset_seq_pkg::osc_running;
    endfunction

    // Shifts the enable pin through the two synchroniser stages.
    // Only the second stage is looked at, so a metastable first stage never
    // reaches the edge detector.
    function automatic reset_seq_pkg::seq_state_type sync_step(
        input reset_seq_pkg::seq_state_type s,
        input logic                         pin
    );
        reset_seq_pkg::seq_state_type r;
        r         = s;
        r.ce_meta = pin;
        r.ce_sync = s.ce_meta;
        r.ce_last = s.ce_sync;
        return r;
    endfunction

    // Low-to-high transition of the synchronised enable pin.
    function automatic logic enable_rose(input reset_seq_pkg::seq_state_type s);
        return s.ce_sync && !s.ce_last;
    endfunction

    // The wave wraps when the count reaches half a period less one.
    // A comparison with >= keeps the wave sane after a shorter mode is chosen.
    function automatic logic wrap_due(
        input reset_seq_pkg::seq_state_type s,
        input logic [cw-1:0]                half
    );
        return osc_live(s.osc) && (s.phase_count >= half - cw'(1));
    endfunction

    // Advances the carry setting wave by one clock; frozen during clock stop.
    function automatic reset_seq_pkg::seq_state_type wave_step(
        input reset_seq_pkg::seq_state_type s,
        input logic                         wrap
    );
        reset_seq_pkg::seq_state_type r;
        r = s;
        if (osc_live(s.osc)) begin
            if (wrap) begin
                r.phase_count = '0;
                r.carry_pulse = !s.carry_pulse;
            end else begin
                r.phase_count = s.phase_count + cw'(1);
            end
        end
        return r;
    endfunction

    // Restarts the wave from phase zero with the pulse low, so the first rise
    // comes half a period later.
    function automatic reset_seq_pkg::seq_state_type wave_restart(
        input reset_seq_pkg::seq_state_type s
    );
        reset_seq_pkg::seq_state_type r;
        r             = s;
        r.phase_count = '0;
        r.carry_pulse = 1'b0;
        return r;
    endfunction

    // Reset outputs are single-cycle pulses unless an event sets them again.
    function automatic reset_seq_pkg::seq_state_type pulse_idle(
        input reset_seq_pkg::seq_state_type s
    );
        reset_seq_pkg::seq_state_type r;
        r                    = s;
        r.halt_force_reset   = 1'b0;
        r.partial_ctrl_reset = 1'b0;
        r.full_reset         = 1'b0;
        return r;
    endfunction

    // Carry flag and forced halt. A set in the same cycle as a clear wins,
    // so a carry is never lost to a late clear.
    function automatic reset_seq_pkg::seq_state_type flag_step(
        input reset_seq_pkg::seq_state_type s,
        input logic                         clear,
        input logic                         carry
    );
        reset_seq_pkg::seq_state_type r;
        r = s;
        if (clear) begin
            r.carry_ff = 1'b0;
        end
        if (carry) begin
            r.carry_ff    = 1'b1;
            r.halt_active = 1'b0;
        end
        return r;
    endfunction

    // Timer mode survives an enable reset; only a partial reset clears it.
    function automatic reset_seq_pkg::seq_state_type mode_step(
        input reset_seq_pkg::seq_state_type s,
        input logic                         write,
        input logic [3:0]                   data
    );
        reset_seq_pkg::seq_state_type r;
        r = s;
        if (write) begin
            r.timer_mode = data;
        end
        return r;
    endfunction

    // Latches an enable edge and fires the full reset on the next carry rise.
    // An edge that meets a carry rise in the same cycle waits a whole period,
    // so the delay from the pin is never zero. Nothing else is asserted
    // meanwhile, so the program keeps running.
    function automatic reset_seq_pkg::seq_state_type enable_step(
        input reset_seq_pkg::seq_state_type s,
        input reset_seq_pkg::seq_state_type n,
        input logic                         rise,
        input logic                         carry
    );
        reset_seq_pkg::seq_state_type r;
        r = n;
        if (carry && s.pending) begin
            r.full_reset = 1'b1;
            r.pending    = 1'b0;
        end
        if (rise) begin
            r.pending = 1'b1;
        end
        if (rise && !osc_live(s.osc)) begin
            // Resuming in the cleared mode puts the reset 50 ms after the pin rise.
            r     = wave_restart(r);
            r.osc = reset_seq_pkg::osc_running;
        end
        return r;
    endfunction

    // Issues the three reset pulses shared by power-on and clock stop.
    // A pending enable edge is dropped: the full reset issued here covers it.
    function automatic reset_seq_pkg::seq_state_type fire_all(
        input reset_seq_pkg::seq_state_type s
    );
        reset_seq_pkg::seq_state_type r;
        r                    = wave_restart(s);
        r.halt_force_reset   = 1'b1;
        r.partial_ctrl_reset = 1'b1;
        r.full_reset         = 1'b1;
        r.halt_active        = 1'b1;
        r.timer_mode         = reset_seq_pkg::mode_reset_value;
        r.pending            = 1'b0;
        return r;
    endfunction

    // Clock stop: all three resets at once, and the oscillator halts in the same cycle.
    function automatic reset_seq_pkg::seq_state_type stop_event(
        input reset_seq_pkg::seq_state_type s
    );
        reset_seq_pkg::seq_state_type r;
        r     = fire_all(s);
        r.osc = reset_seq_pkg::osc_stopped;
        return r;
    endfunction

    // Power-on also clears the carry flag and restarts the oscillator.
    function automatic reset_seq_pkg::seq_state_type power_event(
        input reset_seq_pkg::seq_state_type s
    );
        reset_seq_pkg::seq_state_type r;
        r          = fire_all(s);
        r.carry_ff = 1'b0;
        r.osc      = reset_seq_pkg::osc_running;
        return r;
    endfunction

    logic          ce_rise;
    logic          phase_wrap;
    logic          carry_rise;
    logic [cw-1:0] half_now;

    always_comb begin
        half_now   = half_period(state.timer_mode);
        ce_rise    = enable_rose(state);
        phase_wrap = wrap_due(state, half_now);
        carry_rise = phase_wrap && !state.carry_pulse;

        next_state = sync_step(state, chip_enable);
        next_state = wave_step(next_state, phase_wrap);
        next_state = pulse_idle(next_state);
        next_state = flag_step(next_state, carry_ff_clear, carry_rise);
        next_state = mode_step(next_state, mode_write, mode_data);
        next_state = enable_step(state, next_state, ce_rise, carry_rise);

        // Clock stop overrides the enable path in the same cycle.
        if (stop_exec) begin
            next_state = stop_event(next_state);
        end

        // Power-on takes precedence over every other event.
        if (supply_rise) begin
            next_state = power_event(next_state);
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            state <= reset_seq_pkg::state_reset_value;
        end else if (clock_enable) begin
            state <= next_state;
        end
    end

    // Every output is a field of the registered state.
    // full_reset alone covers the enable reset path.
    assign halt_force_reset   = state.halt_force_reset;
    assign partial_ctrl_reset = state.partial_ctrl_reset;
    assign full_reset         = state.full_reset;
    assign halt_active        = state.halt_active;
    assign carry_ff           = state.carry_ff;
    assign carry_pulse        = state.carry_pulse;
    assign osc_run            = state.osc;
    assign timer_mode         = state.timer_mode;
    assign reset_pending      = state.pending;

endmodule

`default_nettype wire

// ---- verilog/reset_seq_pkg.sv ----
package reset_seq_pkg;

    // Carry setting periods, in microseconds.
    localparam int period_1ms_us   = 1000;
    localparam int period_5ms_us   = 5000;
    localparam int period_100ms_us = 100000;
    localparam int period_250ms_us = 250000;

    // System clock period in nanoseconds (10 MHz).
    localparam int clock_period_ns = 100;

    // Half of each carry period, in clock cycles.
    localparam int half_1ms_cycles   = period_1ms_us * 1000 / clock_period_ns / 2;
    localparam int half_5ms_cycles   = period_5ms_us * 1000 / clock_period_ns / 2;
    localparam int half_100ms_cycles = period_100ms_us * 1000 / clock_period_ns / 2;
    localparam int half_250ms_cycles = period_250ms_us * 1000 / clock_period_ns / 2;

    localparam int count_width = 24;

    // Timer mode select encodings; zero is the value after any partial reset.
    localparam logic [3:0] mode_reset_value = 4'h0;
    localparam logic [1:0] sel_100ms = 2'h0;
    localparam logic [1:0] sel_250ms = 2'h1;
    localparam logic [1:0] sel_5ms   = 2'h2;
    localparam logic [1:0] sel_1ms   = 2'h3;

    // Running encodes one, so the oscillator-run output is the state bit itself.
    typedef enum logic [0:0] {
        osc_running = 1'b1,
        osc_stopped = 1'b0
    } osc_state_type;

    typedef struct packed {
        logic                   ce_meta;
        logic                   ce_sync;
        logic                   ce_last;
        logic                   pending;
        osc_state_type          osc;
        logic                   halt_active;
        logic                   carry_ff;
        logic [3:0]             timer_mode;
        logic [count_width-1:0] phase_count;
        logic                   carry_pulse;
        logic                   halt_force_reset;
        logic                   partial_ctrl_reset;
        logic                   full_reset;
    } seq_state_type;

    // Value after srst: everything clear, with the oscillator running.
    localparam seq_state_type state_reset_value = '{osc: osc_running, default: '0};

endpackage
